// ==== design/ssp_status_pkg.sv ====
package ssp_status_pkg;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL         = 8'h00;        // Control and mode bits
   localparam logic [7:0]  OFS_THRESH       = 8'h04;        // FIFO trigger thresholds
   localparam logic [7:0]  OFS_STATUS       = 8'h08;        // Status and flags
   localparam logic [7:0]  OFS_TIMEOUT      = 8'h0C;        // Receive idle timeout
   // Control bit positions
   localparam int          C_ENABLE         = 0;            // port_enable_bit
   localparam int          C_PACK           = 1;            // fifo_packing_enable
   localparam int          C_EXT_SIZE       = 2;            // extended_sample_size
   localparam int          C_NETWORK        = 3;            // network_frame_select
   localparam int          C_FRM_SLAVE      = 4;            // frame_direction_slave
   localparam int          C_RX_ONLY        = 5;            // receive_only_select
   localparam int          C_FIFO_TEST      = 6;            // fifo_test_mode
   localparam int          C_OVF_MASK       = 8;            // overflow_int_mask
   localparam int          C_UNR_MASK       = 9;            // underrun_int_mask
   localparam int          C_MIS_IE         = 10;           // misalign_int_enable
   localparam int          C_TMO_IE         = 11;           // timeout_int_enable
   localparam int          C_TRL_IE         = 12;           // trailing_int_enable
   localparam int          C_RXS_IE         = 13;           // rx_service_int_enable
   localparam int          C_RXS_DMA        = 14;           // rx_dma_request_enable
   localparam int          C_TXS_IE         = 15;           // tx_service_int_enable
   localparam int          C_TXS_DMA        = 16;           // tx_dma_request_enable
   localparam int          C_WIDTH_LO       = 17;           // Sample width minus one, 5 bits
   localparam logic [31:0] CTRL_WMASK       = 32'h003F_FF7F; // Writable control bits
   // Threshold field positions
   localparam int          T_TX_LO          = 0;            // tx_trigger_threshold
   localparam int          T_RX_LO          = 4;            // Receive threshold
   // Status bit positions
   localparam int          S_RX_ODD         = 31;
   localparam int          S_TX_ODD         = 30;
   localparam int          S_MISALIGN       = 23;
   localparam int          S_CSS            = 22;
   localparam int          S_UNDERRUN       = 21;
   localparam int          S_EOC            = 20;
   localparam int          S_TIMEOUT        = 19;
   localparam int          S_TRAILING       = 18;
   localparam int          S_RFL_LO         = 12;
   localparam int          S_TFL_LO         = 8;
   localparam int          S_OVERRUN        = 7;
   localparam int          S_RFS            = 6;
   localparam int          S_TFS            = 5;
   localparam int          S_BUSY           = 4;
   localparam int          S_RNE            = 3;
   localparam int          S_TNF            = 2;
   // FIFO geometry in samples
   localparam logic [5:0]  FIFO_ENTRIES     = 6'h10;        // 16 entries
   localparam logic [5:0]  PACK_TX_LIMIT    = 6'h1F;        // 31 samples: further writes lost
   localparam logic [5:0]  PACK_RX_LIMIT    = 6'h20;        // 32 samples
   localparam logic [3:0]  RFL_RESET        = 4'hF;         // Receive level at reset
   // Timing
   localparam logic [1:0]  CSS_SYNC_CYCLES  = 2'h3;         // Cycles to pass settings to serial clock
   localparam logic [1:0]  MISALIGN_DROP    = 2'h2;         // Samples dropped after misalignment
endpackage : ssp_status_pkg

// ==== design/ssp_status_flag_logic.sv ====
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Busy flag high while shifting, off when idle
// - Receive not-empty flag follows receive FIFO content
// - Transmit not-full flag low only when full unpacked, never low when packed
// - Receive odd-sample flag, zero without packing
// - Packed: odd transmit flag, discard write at 31
// - Sticky misalignment flag, W1C, optional interrupt
// - Misalignment drops current and next sample
// - Clock-sync pending while settings cross domains
// - Sticky underrun flag, W1C, maskable interrupt
// - Underrun only slave or network, not receive-only
// - Sticky end-of-chain flag, W1C
// - Sticky receive timeout flag, W1C, interrupt
// - Trailing-byte flag on end-of-chain with data
// - Receive level is entries minus one
// - Packed receive samples from level and odd
// - Transmit level is valid entry count
// - Packed transmit samples from level and odd
// - Overrun discards data, sticky W1C flag
// - Receive service above threshold, irq or DMA
// - Transmit service at/below threshold, irq or DMA
// - Sticky flags reset; disable clears all status
module ssp_status_flag_logic
   import ssp_status_pkg::*;
(
   input  wire logic        clk_i,            // 200 MHz clock
   input  wire logic        rst_i,            // Synchronous reset, active high
   input  wire logic        ce_i,             // Clock enable, freezes all state when low
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // FIFO and shift engine events, same clock
   input  wire logic        tx_wr_i,          // One sample written toward transmit FIFO
   input  wire logic        tx_rd_i,          // Transmitter takes one sample
   input  wire logic        rx_wr_i,          // Receiver delivers one sample
   input  wire logic        rx_rd_i,          // One sample read from receive FIFO
   input  wire logic        shift_active_i,   // Shift engine moving framed data
   input  wire logic        dma_eoc_i,        // DMA end of receive chain, pulse
   // Serial pins, asynchronous
   input  wire logic        frame_sync_line_i,
   input  wire logic        serial_clock_line_i,
   // Requests
   output logic             irq_o,
   output logic             rx_dma_req_o,
   output logic             tx_dma_req_o,
   output logic             rx_drop_o         // Sample discarded in the previous cycle
);

   // Whole state of the block
   typedef struct packed {
      logic [31:0] ctrl;        // Control word
      logic [7:0]  thr;         // Thresholds
      logic [23:0] tmo;         // Idle timeout value
      logic [5:0]  tx_cnt;      // Transmit samples held
      logic [5:0]  rx_cnt;      // Receive samples held
      logic        misalign;
      logic        underrun;
      logic        eoc;
      logic        timeout;
      logic        trailing;
      logic        overrun;
      logic        clock_sync_pending;
      logic [1:0]  css_cnt;
      logic [23:0] idle_cnt;
      logic        fs_a;        // Frame synchroniser stage one
      logic        fs_b;
      logic        fs_d;
      logic        sc_a;        // Serial clock synchroniser stage one
      logic        sc_b;
      logic        sc_d;
      logic [5:0]  bit_cnt;     // Bits of current sample
      logic [1:0]  drop_cnt;    // Samples still to drop
      logic        busy;
      logic        ack;
      logic [31:0] dat;
      logic        irq;
      logic        rx_dma;
      logic        tx_dma;
      logic        drop;
   } state_t;

   state_t st_ff;               // Registered state
   state_t nxt_st;              // Next state

   // Entries occupied for a sample count
   function automatic logic [5:0] entries(input logic [5:0] cnt, input logic pk);
      logic [6:0] sum;
      sum = {1'b0, cnt} + 7'h01;
      return pk ? sum[6:1] : cnt;
   endfunction : entries

   // Byte-lane mask from select lines
   function automatic logic [31:0] lanes(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lanes

   // Derived conditions
   logic        en;             // Port enabled
   logic        pk;             // Packing in effect
   logic [5:0]  tx_ent;         // Transmit entries
   logic [5:0]  rx_ent;         // Receive entries
   logic        tx_full;        // No more transmit samples accepted
   logic        rx_full;        // No more receive samples accepted
   logic        tx_fifo_has_space;            // Transmit not full as reported
   logic        rx_service_request;            // Receive service condition
   logic        tx_service_request;            // Transmit service condition
   logic [3:0]  rx_fifo_level;
   logic [3:0]  tx_fifo_level;
   logic [31:0] status;         // Status word as read
   logic        wr_hit;         // Write taking effect this cycle
   logic [31:0] wmask;          // Written byte lanes

   // Status word assembly
   always_comb begin
      en      = st_ff.ctrl[C_ENABLE];
      pk      = st_ff.ctrl[C_PACK] & ~st_ff.ctrl[C_EXT_SIZE];
      tx_ent  = entries(st_ff.tx_cnt, pk);
      rx_ent  = entries(st_ff.rx_cnt, pk);
      tx_full = pk ? (st_ff.tx_cnt == PACK_TX_LIMIT) : (st_ff.tx_cnt == FIFO_ENTRIES);
      rx_full = pk ? (st_ff.rx_cnt == PACK_RX_LIMIT) : (st_ff.rx_cnt == FIFO_ENTRIES);
      // Packed: full pairs below sixteen still read as not full
      tx_fifo_has_space     = pk ? (st_ff.tx_cnt[5:1] != 5'h10) : (st_ff.tx_cnt != FIFO_ENTRIES);
      rx_fifo_level     = pk ? (st_ff.rx_cnt[4:1] + {3'h0, st_ff.rx_cnt[0]} - 4'h1)
                   : (st_ff.rx_cnt[3:0] - 4'h1);
      tx_fifo_level     = pk ? st_ff.tx_cnt[4:1] : st_ff.tx_cnt[3:0];
      rx_service_request     = en & (rx_ent > {2'h0, st_ff.thr[T_RX_LO +: 4]});
      tx_service_request     = en & (tx_ent <= {2'h0, st_ff.thr[T_TX_LO +: 4]});
      status  = 32'h0000_0000;
      status[S_RX_ODD]       = pk & st_ff.rx_cnt[0];
      status[S_TX_ODD]       = pk & st_ff.tx_cnt[0];
      status[S_MISALIGN]     = st_ff.misalign;
      status[S_CSS]          = en & st_ff.clock_sync_pending;
      status[S_UNDERRUN]     = st_ff.underrun;
      status[S_EOC]          = st_ff.eoc;
      status[S_TIMEOUT]      = st_ff.timeout;
      status[S_TRAILING]     = st_ff.trailing;
      status[S_RFL_LO +: 4]  = en ? rx_fifo_level : RFL_RESET;
      status[S_TFL_LO +: 4]  = tx_fifo_level;
      status[S_OVERRUN]      = st_ff.overrun;
      status[S_RFS]          = rx_service_request;
      status[S_TFS]          = tx_service_request;
      status[S_BUSY]         = st_ff.busy;
      status[S_RNE]          = st_ff.rx_cnt != 6'h00;
      status[S_TNF]          = tx_fifo_has_space;
      wr_hit  = cyc_i & stb_i & we_i & st_ff.ack;
      wmask   = lanes(sel_i);
   end

   // Next state
   always_comb begin
      logic rx_inc;
      logic rx_dec;
      logic tx_inc;
      logic tx_dec;
      logic fr_rise;
      logic sc_rise;
      logic [31:0] clr;
      rx_inc  = 1'b0;
      rx_dec  = 1'b0;
      tx_inc  = 1'b0;
      tx_dec  = 1'b0;
      fr_rise = st_ff.fs_b & ~st_ff.fs_d;
      sc_rise = st_ff.sc_b & ~st_ff.sc_d;
      clr     = 32'h0000_0000;
      nxt_st  = st_ff;
      // Pin synchronisers and edge history
      nxt_st.fs_a = frame_sync_line_i;
      nxt_st.fs_b = st_ff.fs_a;
      nxt_st.fs_d = st_ff.fs_b;
      nxt_st.sc_a = serial_clock_line_i;
      nxt_st.sc_b = st_ff.sc_a;
      nxt_st.sc_d = st_ff.sc_b;
      // Bus answer, one wait state then ack for one cycle
      nxt_st.ack  = cyc_i & stb_i & ~st_ff.ack;
      if (cyc_i & stb_i & ~st_ff.ack) begin
         case (adr_i)
            OFS_CTRL:    nxt_st.dat = st_ff.ctrl;
            OFS_THRESH:  nxt_st.dat = {24'h00_0000, st_ff.thr};
            OFS_STATUS:  nxt_st.dat = status;
            OFS_TIMEOUT: nxt_st.dat = {8'h00, st_ff.tmo};
            default:     nxt_st.dat = 32'h0000_0000; // Unmapped reads zero
         endcase
      end
      // Register writes
      if (wr_hit) begin
         case (adr_i)
            OFS_CTRL: begin
               nxt_st.ctrl = (st_ff.ctrl & ~(wmask & CTRL_WMASK)) | (dat_i & wmask & CTRL_WMASK);
               nxt_st.clock_sync_pending     = 1'b1;
               nxt_st.css_cnt = CSS_SYNC_CYCLES;
            end
            OFS_THRESH:  nxt_st.thr = (st_ff.thr & ~wmask[7:0]) | (dat_i[7:0] & wmask[7:0]);
            OFS_TIMEOUT: nxt_st.tmo = (st_ff.tmo & ~wmask[23:0]) | (dat_i[23:0] & wmask[23:0]);
            OFS_STATUS:  clr = dat_i & wmask; // Ones clear sticky bits, zeros ignored
            default: begin
               // Unmapped writes are ignored
            end
         endcase
      end
      // Clearing by software, overridden below by new events
      if (clr[S_MISALIGN]) nxt_st.misalign = 1'b0;
      if (clr[S_UNDERRUN]) nxt_st.underrun = 1'b0;
      if (clr[S_EOC])      nxt_st.eoc      = 1'b0;
      if (clr[S_TIMEOUT])  nxt_st.timeout  = 1'b0;
      if (clr[S_TRAILING]) nxt_st.trailing = 1'b0;
      if (clr[S_OVERRUN])  nxt_st.overrun  = 1'b0;
      // Settings crossing into the serial clock domain
      if (!(wr_hit && adr_i == OFS_CTRL) && st_ff.clock_sync_pending) begin
         if (st_ff.css_cnt == 2'h0) nxt_st.clock_sync_pending = 1'b0;
         else nxt_st.css_cnt = st_ff.css_cnt - 2'h1;
      end
      nxt_st.drop = 1'b0;
      if (en) begin
         // Transmit side
         tx_inc = tx_wr_i & ~tx_full;
         tx_dec = tx_rd_i & (st_ff.tx_cnt != 6'h00);
         if (tx_rd_i && st_ff.tx_cnt == 6'h00 && !st_ff.ctrl[C_RX_ONLY] &&
             (st_ff.ctrl[C_FRM_SLAVE] || st_ff.ctrl[C_NETWORK])) begin
            nxt_st.underrun = 1'b1;
         end
         // Receive side, dropping after misalignment
         if (rx_wr_i && st_ff.drop_cnt != 2'h0) begin
            nxt_st.drop_cnt = st_ff.drop_cnt - 2'h1;
            nxt_st.drop     = 1'b1;
         end else if (rx_wr_i && rx_full) begin
            nxt_st.overrun = 1'b1;
            nxt_st.drop    = 1'b1;
         end else begin
            rx_inc = rx_wr_i;
         end
         rx_dec = rx_rd_i & (st_ff.rx_cnt != 6'h00);
         // Frame misalignment: frame rises mid-sample
         if (fr_rise && st_ff.bit_cnt != 6'h00) begin
            nxt_st.misalign = 1'b1;
            nxt_st.drop_cnt = MISALIGN_DROP;
            nxt_st.bit_cnt  = 6'h00;
         end else if (fr_rise) begin
            nxt_st.bit_cnt = 6'h00;
         end else if (sc_rise && (st_ff.fs_b || st_ff.bit_cnt != 6'h00)) begin
            if (st_ff.bit_cnt == {1'b0, st_ff.ctrl[C_WIDTH_LO +: 5]}) nxt_st.bit_cnt = 6'h00;
            else nxt_st.bit_cnt = st_ff.bit_cnt + 6'h01;
         end
         // End of chain and trailing data
         if (dma_eoc_i) begin
            nxt_st.eoc = 1'b1;
            if (st_ff.rx_cnt != 6'h00) nxt_st.trailing = 1'b1;
         end
         // Receive idle timeout
         if (rx_inc || st_ff.rx_cnt == 6'h00 || st_ff.tmo == 24'h00_0000) begin
            nxt_st.idle_cnt = 24'h00_0000;
         end else if (st_ff.idle_cnt != st_ff.tmo) begin
            nxt_st.idle_cnt = st_ff.idle_cnt + 24'h00_0001;
            if (st_ff.idle_cnt + 24'h00_0001 == st_ff.tmo) nxt_st.timeout = 1'b1;
         end
         nxt_st.tx_cnt = st_ff.tx_cnt + {5'h00, tx_inc} - {5'h00, tx_dec};
         nxt_st.rx_cnt = st_ff.rx_cnt + {5'h00, rx_inc} - {5'h00, rx_dec};
         nxt_st.busy   = shift_active_i;
      end else begin
         // Disabled: FIFOs empty and every status bit at reset value
         nxt_st.tx_cnt   = 6'h00;
         nxt_st.rx_cnt   = 6'h00;
         nxt_st.misalign = 1'b0;
         nxt_st.underrun = 1'b0;
         nxt_st.eoc      = 1'b0;
         nxt_st.timeout  = 1'b0;
         nxt_st.trailing = 1'b0;
         nxt_st.overrun  = 1'b0;
         nxt_st.busy     = 1'b0;
         nxt_st.idle_cnt = 24'h00_0000;
         nxt_st.bit_cnt  = 6'h00;
         nxt_st.drop_cnt = 2'h0;
      end
      // Request outputs from current flags
      nxt_st.irq = (st_ff.overrun  & ~st_ff.ctrl[C_OVF_MASK]) |
                   (st_ff.underrun & ~st_ff.ctrl[C_UNR_MASK]) |
                   (st_ff.misalign &  st_ff.ctrl[C_MIS_IE])   |
                   (st_ff.timeout  &  st_ff.ctrl[C_TMO_IE])   |
                   (st_ff.trailing &  st_ff.ctrl[C_TRL_IE])   |
                   (rx_service_request & st_ff.ctrl[C_RXS_IE]) |
                   (tx_service_request & st_ff.ctrl[C_TXS_IE]);
      nxt_st.rx_dma = rx_service_request & st_ff.ctrl[C_RXS_DMA];
      nxt_st.tx_dma = tx_service_request & st_ff.ctrl[C_TXS_DMA];
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops
   assign dat_o        = st_ff.dat;
   assign ack_o        = st_ff.ack;
   assign irq_o        = st_ff.irq;
   assign rx_dma_req_o = st_ff.rx_dma;
   assign tx_dma_req_o = st_ff.tx_dma;
   assign rx_drop_o    = st_ff.drop;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_busy_off_idle: assert property (ce_i && !en |=> !st_ff.busy)
      else $error("busy set while disabled");
   a_rne_first_sample: assert property (ce_i && en && rx_wr_i && !rx_rd_i && st_ff.rx_cnt == 6'h00 &&
                                        st_ff.drop_cnt == 2'h0 ##1 ce_i |-> status[S_RNE])
      else $error("not-empty missing after first sample");
   a_tnf_when_full: assert property (!pk && st_ff.tx_cnt == FIFO_ENTRIES |-> !tx_fifo_has_space)
      else $error("not-full high with full transmit FIFO");
   a_pack_write_lost: assert property (ce_i && en && pk && st_ff.tx_cnt == PACK_TX_LIMIT &&
                                       !tx_rd_i |=> st_ff.tx_cnt == PACK_TX_LIMIT)
      else $error("packed write accepted at 31 samples");
   a_overrun_discard: assert property (ce_i && en && rx_full && rx_wr_i && !rx_rd_i &&
                                       st_ff.drop_cnt == 2'h0 |=> st_ff.overrun && $stable(st_ff.rx_cnt))
      else $error("overrun not flagged or data kept");
   a_underrun_rx_only: assert property (ce_i && st_ff.ctrl[C_RX_ONLY] && !st_ff.underrun |=> !st_ff.underrun)
      else $error("underrun set in receive-only mode");
   a_rx_dma_req: assert property (ce_i && rx_service_request && st_ff.ctrl[C_RXS_DMA] |=> rx_dma_req_o)
      else $error("receive DMA request missing");
   a_disable_clear: assert property (ce_i && !en |=> st_ff.overrun == 1'b0 && st_ff.rx_cnt == 6'h00 &&
                                     st_ff.underrun == 1'b0)
      else $error("status not cleared when disabled");
   a_irq_overrun: assert property (ce_i && st_ff.overrun && !st_ff.ctrl[C_OVF_MASK] |=> irq_o)
      else $error("overrun interrupt missing");
   a_css_bounded: assert property ((ce_i && st_ff.clock_sync_pending && !(wr_hit && adr_i == OFS_CTRL)) [*4] |=> !st_ff.clock_sync_pending)
      else $error("clock sync flag stuck");

endmodule : ssp_status_flag_logic

// ==== tb/ssp_link_model.sv ====
`timescale 1ns/1ps
// Far-side frame master; its serial clock runs only inside frames
module ssp_link_model (
   input  wire logic go_i,     // Rising edge starts one 8-bit frame
   input  wire logic bad_i,    // Re-raise the frame in mid-word
   output logic      frame_o,  // Frame sync line, idle low
   output logic      sclk_o    // Serial clock line, idle low
);
   // Frame generator, 48 ns serial clock period
   initial begin
      frame_o = 1'b0;
      sclk_o  = 1'b0;
      forever begin
         @(posedge go_i); // Bench raises go only once sync has cleared
         frame_o = 1'b1;
         for (int i = 0; i < 8; i++) begin
            #24 sclk_o = 1'b1;
            #24 sclk_o = 1'b0;
            // Misplaced frame edge after the third bit
            if (bad_i && i == 2) begin
               frame_o = 1'b0;
               #24 frame_o = 1'b1;
            end
         end
         frame_o = 1'b0; // Clock stands still between frames
      end
   end
endmodule : ssp_link_model

// ==== tb/ssp_status_flag_logic_test.sv ====
`timescale 1ns/1ps
module ssp_status_flag_logic_test;
   import ssp_status_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, shift, go, bad;  // Bench-driven controls
   logic [7:0]  adr_i;                                              // Bus address
   logic [31:0] dat_i, dat_o, rdat, lf;                             // Bus data, last read, random state
   logic [4:0]  ev;                                                 // tx_wr, tx_rd, rx_wr, rx_rd, dma_eoc
   logic        ack_o, irq_o, rxd, txd, frm, sck, drp;              // Design outputs and link lines
   int          n_fail, n_checks, n, k, rt, tt, n_drop;             // Counters and random picks
   localparam logic [4:0] TXW = 5'h10, TXR = 5'h08, RXW = 5'h04, EOC = 5'h01;

   ssp_status_flag_logic dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .tx_wr_i(ev[4]), .tx_rd_i(ev[3]), .rx_wr_i(ev[2]), .rx_rd_i(ev[1]), .shift_active_i(shift),
      .dma_eoc_i(ev[0]), .frame_sync_line_i(frm), .serial_clock_line_i(sck), .irq_o(irq_o),
      .rx_dma_req_o(rxd), .tx_dma_req_o(txd), .rx_drop_o(drp));
   ssp_link_model link_u (.go_i(go), .bad_i(bad), .frame_o(frm), .sclk_o(sck));

   // Single bit mask
   function automatic logic [31:0] b(input int p);
      return 32'h0000_0001 << p;
   endfunction : b
   // Random numbers from a shift register
   function automatic int rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return int'(lf[15:0]);
   endfunction : rnd
   // Expected status for n received and k sent samples, unpacked
   function automatic logic [31:0] exp_lvl(input int n, input int k, input int r, input int t);
      return {16'h0, 4'(n - 1), 4'(k), 1'b0, 1'(n > r), 1'(k <= t), 2'b01, 1'(k < 16), 2'b00};
   endfunction : exp_lvl
   // Word compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Classic Wishbone cycle, holds the request until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rdat = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask : wb
   // Masked status read
   task automatic st(input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, OFS_STATUS, 32'h0);
      chk(rdat & m, e);
   endtask : st
   // Disable, then enable with extra control bits
   task automatic mode(input logic [31:0] c);
      wb(1'b1, OFS_CTRL, 32'h0);
      wb(1'b1, OFS_CTRL, c | b(C_ENABLE));
   endtask : mode
   // Event pulses for n cycles
   task automatic pulse(input logic [4:0] m, input int n);
      repeat (n) begin
         @(posedge clk_i);
         ev <= m;
      end
      @(posedge clk_i);
      ev <= 5'h00;
   endtask : pulse
   // Sticky bit: set with irq, a written 0 ignored, a written 1 clears
   task automatic w1c(input int p);
      st(b(p), b(p));
      chk({31'h0, irq_o}, 32'h1);
      wb(1'b1, OFS_STATUS, 32'h0);
      st(b(p), b(p));
      wb(1'b1, OFS_STATUS, b(p));
      st(b(p), 32'h0);
      chk({31'h0, irq_o}, 32'h0);
   endtask : w1c
   // Verdict
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Samples discarded by the design, counted outside reset
   always @(posedge clk_i) begin
      if (!rst_i && drp) n_drop <= n_drop + 1;
   end
   // Watchdog
   initial begin
      #200000;
      n_fail++;
      $display("wrong value at %0t: watchdog expired", $time);
      test_done();
   end
   // Main sequence
   initial begin
      {rst_i, cyc_i, stb_i, we_i, shift, go, bad, ev, adr_i, dat_i} = {1'b1, 51'h0};
      {n_fail, n_checks, lf} = {64'h0, 32'd77183};
      n_drop = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      st(32'hFFFF_FFFC, 32'h0000_F004);
      wb(1'b0, 8'h10, 32'h0);
      chk(rdat, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         {rt, tt, n, k} = {rnd() % 15, rnd() % 15, rnd() % 16 + 1, rnd() % 16 + 1};
         wb(1'b1, OFS_THRESH, 32'(rt * 16 + tt));
         mode(b(C_RXS_DMA) | b(C_TXS_DMA));
         st(b(S_CSS), b(S_CSS));
         pulse(RXW, n);
         pulse(TXW, k);
         repeat (4) @(posedge clk_i);
         st(32'hFFFF_FFFC, exp_lvl(n, k, rt, tt));
         chk({29'h0, irq_o, rxd, txd}, {29'h0, 1'b0, 1'(n > rt), 1'(k <= tt)});
      end
      $display("test levels done");
      mode(32'h0);
      pulse(RXW, 17);
      st(32'h0000_F008, 32'h0000_F008);
      w1c(S_OVERRUN);
      for (int i = 0; i < 4; i++) begin
         mode(i == 0 ? b(C_FRM_SLAVE) : i == 1 ? b(C_NETWORK) : i == 2 ? b(C_FRM_SLAVE) | b(C_RX_ONLY) : 0);
         pulse(TXR, 1);
         st(b(S_UNDERRUN), (i < 2) ? b(S_UNDERRUN) : 32'h0);
      end
      mode(b(C_FRM_SLAVE));
      pulse(TXR, 1);
      w1c(S_UNDERRUN);
      $display("test errors done");
      mode(b(C_TRL_IE));
      pulse(EOC, 1);
      st(b(S_EOC) | b(S_TRAILING), b(S_EOC));
      wb(1'b1, OFS_STATUS, b(S_EOC));
      st(b(S_EOC), 32'h0);
      pulse(RXW, 2);
      pulse(EOC, 1);
      st(b(S_EOC), b(S_EOC));
      w1c(S_TRAILING);
      wb(1'b1, OFS_TIMEOUT, 32'h0000_00C8);
      mode(b(C_TMO_IE));
      pulse(RXW, 1);
      repeat (150) @(posedge clk_i);
      st(b(S_TIMEOUT), 32'h0);
      repeat (70) @(posedge clk_i);
      w1c(S_TIMEOUT);
      $display("test events done");
      mode(b(C_PACK));
      pulse(TXW, 32);
      pulse(RXW, 3);
      st(32'hC000_FF0C, 32'hC000_1F0C);
      $display("test packing done");
      mode(b(C_MIS_IE) | b(C_FRM_SLAVE) | (32'h0000_0007 << C_WIDTH_LO));
      repeat (8) @(posedge clk_i);
      st(b(S_CSS), 32'h0);
      {go, bad} <= 2'b10;
      repeat (100) @(posedge clk_i);
      st(b(S_MISALIGN), 32'h0);
      {go, bad} <= 2'b00;
      @(posedge clk_i);
      {go, bad} <= 2'b11;
      repeat (100) @(posedge clk_i);
      pulse(RXW, 2);
      st(b(S_RNE), 32'h0);
      chk(32'(n_drop), 32'h0000_0003);
      pulse(RXW, 1);
      st(b(S_RNE), b(S_RNE));
      w1c(S_MISALIGN);
      $display("test link done");
      shift <= 1'b1;
      st(b(S_BUSY), b(S_BUSY));
      chk({31'h0, irq_o}, 32'h0);
      wb(1'b1, OFS_CTRL, 32'h0);
      st(32'hFFFF_FFFC, 32'h0000_F004);
      shift <= 1'b0;
      $display("test busy done");
      test_done();
   end
endmodule : ssp_status_flag_logic_test
